// ---- rtl/rsr_consts.svh ----
// Purpose: constants for the remote status reporting block
// Assumes: included by its bare name
// Notes: bit positions, reset values, indicator timing
`ifndef RSR_CONSTS_SVH
`define RSR_CONSTS_SVH

// Serial poll status byte bits
`define RSR_SPB_READY 0
`define RSR_SPB_MEAS_SUM 3
`define RSR_SPB_MAV 4
`define RSR_SPB_ESB 5
`define RSR_SPB_RQS 6
`define RSR_SPB_NO_CMD 7

// Standard event bits
`define RSR_SEV_OPC 0
`define RSR_SEV_QUERY_ERR 2
`define RSR_SEV_EXEC_ERR 4
`define RSR_SEV_CMD_ERR 5
`define RSR_SEV_KEY 6
`define RSR_SEV_PON 7
`define RSR_SEV_USED_MASK 8'hf5

// Measurement status bits
`define RSR_MST_MATH 0
`define RSR_MST_ADC 1
`define RSR_MST_OVLD 2
`define RSR_MST_UNDER 3
`define RSR_MST_OVER 4
`define RSR_MST_NO_MEAS 5
`define RSR_MST_MEM 7
`define RSR_MST_USED_MASK 8'hbf

// Reset values
`define RSR_MASK_RST 8'h00
`define RSR_PSC_RST 1'b1

// Indicator flash time
`define RSR_CLK_NS 25
`define RSR_FLASH_NS 50000000
`define RSR_FLASH_CYC ((`RSR_FLASH_NS + `RSR_CLK_NS - 1) / `RSR_CLK_NS)

`endif

// ---- rtl/rsr_pkg.sv ----
// Purpose: types for the remote status reporting block
// Assumes: nothing
// Notes: calibration result codes
package rsr_pkg;
  typedef enum logic [2:0] {
    RSR_CAL_OK = 3'h0,
    RSR_CAL_MEAS_ERR = 3'h1,
    RSR_CAL_SHORT_HIGH = 3'h2,
    RSR_CAL_OPEN_LOW = 3'h3,
    RSR_CAL_STD_RANGE = 3'h4
  } rsr_cal_e;

  typedef enum logic [1:0] {
    RSR_FL_IDLE = 2'b01,
    RSR_FL_ON = 2'b10
  } rsr_flash_e;
endpackage

// ---- rtl/rsr_flash.sv ----
// Purpose: retriggerable indicator flash stretcher
// Assumes: one clock, synchronous active high reset
// Notes: a trigger while lit restarts the full time
module rsr_flash
  import rsr_pkg::*;
#(
  parameter int unsigned FLASH_CYC = 2000000
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Trigger and lamp
  input wire logic i_trig,
  output logic o_lamp
);
  localparam int unsigned CW = $clog2(FLASH_CYC + 1);

  // Zero length would leave the lamp dark after every trigger
  if (FLASH_CYC < 1) begin : g_bad_flash
    $error("FLASH_CYC must be at least one");
  end

  rsr_flash_e state_q, state_d;
  logic [CW-1:0] cnt_q, cnt_d;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      RSR_FL_IDLE: begin
        if (i_trig) begin
          state_d = RSR_FL_ON;
          cnt_d = CW'(FLASH_CYC - 1);
        end
      end
      RSR_FL_ON: begin
        if (i_trig) begin
          cnt_d = CW'(FLASH_CYC - 1);
        end else if (cnt_q == '0) begin
          state_d = RSR_FL_IDLE;
        end else begin
          cnt_d = cnt_q - CW'(1);
        end
      end
      default: begin
        state_d = RSR_FL_IDLE;
        cnt_d = '0;
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_q <= RSR_FL_IDLE;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  assign o_lamp = (state_q == RSR_FL_ON);
endmodule

// ---- rtl/rsr_status.sv ----
// Purpose: status bytes, event registers and indicators for the remote interface
// Assumes: the command parser decodes commands and drives one-cycle strobes
// Notes: registers are read through dedicated output ports, no bus
//
// Summary of operation
// - Calibration result reported as code 0 to 4.
// - Activity lamp flashes on each character sent or received.
// - Error lamp flashes on any command error, execution error or output queue overflow.
// - Remote lamp lit in remote state; front panel locked out then.
// - Syntax faults are command errors and set event bit 5.
// - Failure of a valid command sets event bit 4.
// - No-command bit clears on queued command, sets when queue drained.
// - No-command bit visible by GPIB serial poll only, not RS232.
// - Status byte query returns no-command bit as 0.
// - Poll bit 0 shows ready to measure; bits 1 and 2 unused.
// - Poll bit 3 set when any enabled measurement status bit set.
// - Poll bit 4 set while GPIB output queue holds a response.
// - Poll bit 5 set when any enabled standard event bit set.
// - Poll bit 6 is the service request indication with SRQ.
// - After operation-complete command, event bit 0 set when measurements done.
// - Output queue overflow sets event bit 2.
// - Key press sets event bit 6, power-on bit 7; bits 1,3 unused.
// - Math fault sets measurement bit 0, conversion fault bit 1.
// - Gain overload sets measurement bit 2.
// - Under range sets measurement bit 3, over range bit 4.
// - No valid measurement sets bit 5; bit 6 unused.
// - Invalid stored settings at power-up set measurement bit 7.
// - Host writes three 8-bit enable masks feeding the summary bits.
// - Clear-status command clears the event and measurement status registers; enable masks are kept.
// - Power-on-clear setting chooses clearing or keeping status at power-on.
`include "rsr_consts.svh"

module rsr_status
  import rsr_pkg::*;
#(
  parameter int unsigned FLASH_CYC = `RSR_FLASH_CYC
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Power-on and stored setting state
  input wire logic i_power_on,
  input wire logic i_psc_nv,
  input wire logic i_settings_invalid,
  // Host command strobes
  input wire logic i_cls,
  input wire logic i_opc_cmd,
  input wire logic i_psc_wr,
  input wire logic i_psc_val,
  input wire logic i_ese_wr,
  input wire logic i_sre_wr,
  input wire logic i_measurement_mask_write,
  input wire logic [7:0] i_mask_data,
  input wire logic i_stb_query,
  // Command queue and errors
  input wire logic i_cmd_enqueued,
  input wire logic i_queue_drained,
  input wire logic i_cmd_err,
  input wire logic i_exec_err,
  input wire logic i_outq_overflow,
  input wire logic i_gpib_outq_nonempty,
  // Measurement engine
  input wire logic i_ready,
  input wire logic i_meas_busy,
  input wire logic i_math_fault,
  input wire logic i_adc_fault,
  input wire logic i_overload,
  input wire logic i_under_range,
  input wire logic i_over_range,
  input wire logic i_no_meas,
  // Calibration
  input wire logic i_cal_done,
  input wire logic [2:0] i_cal_code,
  // Front panel and link
  input wire logic i_key_press,
  input wire logic i_char_xfer,
  input wire logic i_remote,
  // Register contents
  output logic [7:0] o_spoll_byte,
  output logic [7:0] o_stb_query_byte,
  output logic [7:0] o_standard_event_status,
  output logic [7:0] o_measurement_status,
  output logic [7:0] o_ese_mask,
  output logic [7:0] o_sre_mask,
  output logic [7:0] o_meas_mask,
  output logic o_psc,
  output logic [2:0] o_cal_result,
  output logic o_srq,
  // Indicators
  output logic o_activity_indicator,
  output logic o_error_indicator,
  output logic o_remote_indicator,
  output logic o_panel_lockout
);
  function automatic logic any_enabled(input logic [7:0] ev, input logic [7:0] en);
    any_enabled = |(ev & en);
  endfunction

  // Event and configuration state
  logic [7:0] sev_q, sev_d;
  logic [7:0] mst_q, mst_d;
  logic [7:0] ese_q, ese_d, sre_q, sre_d, mmask_q, mmask_d;
  logic psc_q, psc_d;
  logic no_cmd_q, no_cmd_d;
  logic opc_arm_q, opc_arm_d;
  logic pon_q, pon_d;
  rsr_cal_e cal_q, cal_d;
  logic [7:0] spb_d, stb_d;
  logic [7:0] spb_q, stb_q;
  logic [7:0] sev_set, mst_set;
  logic pon_edge, pon_clear, meas_sum, esb_sum, rqs;

  // Power-on pulse; clearing on power-on is gated by the setting
  assign pon_edge = i_power_on & ~pon_q;
  assign pon_clear = pon_edge & psc_q;

  always_comb begin
    sev_set = 8'h00;
    sev_set[`RSR_SEV_OPC] = opc_arm_q & ~i_meas_busy;
    sev_set[`RSR_SEV_QUERY_ERR] = i_outq_overflow;
    sev_set[`RSR_SEV_EXEC_ERR] = i_exec_err;
    sev_set[`RSR_SEV_CMD_ERR] = i_cmd_err;
    sev_set[`RSR_SEV_KEY] = i_key_press;
    sev_set[`RSR_SEV_PON] = pon_edge;
    mst_set = 8'h00;
    mst_set[`RSR_MST_MATH] = i_math_fault;
    mst_set[`RSR_MST_ADC] = i_adc_fault;
    mst_set[`RSR_MST_OVLD] = i_overload;
    mst_set[`RSR_MST_UNDER] = i_under_range;
    mst_set[`RSR_MST_OVER] = i_over_range;
    mst_set[`RSR_MST_NO_MEAS] = i_no_meas;
    mst_set[`RSR_MST_MEM] = pon_edge & i_settings_invalid;
  end

  always_comb begin
    sev_d = sev_q;
    mst_d = mst_q;
    // Clear first so an event in the same cycle still lands
    if (i_cls || pon_clear) begin
      sev_d = 8'h00;
      mst_d = 8'h00;
    end
    sev_d = sev_d | (sev_set & `RSR_SEV_USED_MASK);
    mst_d = mst_d | (mst_set & `RSR_MST_USED_MASK);
  end

  always_comb begin
    ese_d = i_ese_wr ? i_mask_data : ese_q;
    sre_d = i_sre_wr ? i_mask_data : sre_q;
    mmask_d = i_measurement_mask_write ? i_mask_data : mmask_q;
    if (pon_clear) begin
      ese_d = `RSR_MASK_RST;
      sre_d = `RSR_MASK_RST;
      mmask_d = `RSR_MASK_RST;
    end
    psc_d = i_psc_wr ? i_psc_val : psc_q;
    pon_d = i_power_on;
  end

  // Queue flag: enqueue wins, a new command keeps the queue busy
  always_comb begin
    no_cmd_d = no_cmd_q;
    if (i_queue_drained) begin
      no_cmd_d = 1'b1;
    end
    if (i_cmd_enqueued) begin
      no_cmd_d = 1'b0;
    end
  end

  always_comb begin
    opc_arm_d = opc_arm_q;
    if (opc_arm_q && !i_meas_busy) begin
      opc_arm_d = 1'b0;
    end
    if (i_opc_cmd) begin
      opc_arm_d = 1'b1;
    end
    if (i_cls) begin
      opc_arm_d = 1'b0;
    end
  end

  always_comb begin
    cal_d = cal_q;
    if (i_cal_done) begin
      case (i_cal_code)
        3'h0: cal_d = RSR_CAL_OK;
        3'h1: cal_d = RSR_CAL_MEAS_ERR;
        3'h2: cal_d = RSR_CAL_SHORT_HIGH;
        3'h3: cal_d = RSR_CAL_OPEN_LOW;
        3'h4: cal_d = RSR_CAL_STD_RANGE;
        default: cal_d = RSR_CAL_MEAS_ERR;
      endcase
    end
  end

  // Summaries use the latched sources, live each cycle
  assign meas_sum = any_enabled(mst_q, mmask_q);
  assign esb_sum = any_enabled(sev_q, ese_q);

  always_comb begin
    spb_d = 8'h00;
    spb_d[`RSR_SPB_READY] = i_ready;
    spb_d[`RSR_SPB_MEAS_SUM] = meas_sum;
    spb_d[`RSR_SPB_MAV] = i_gpib_outq_nonempty;
    spb_d[`RSR_SPB_ESB] = esb_sum;
    spb_d[`RSR_SPB_NO_CMD] = no_cmd_q;
    // Bit 6 never enables itself
    spb_d[`RSR_SPB_RQS] = any_enabled(spb_d, sre_q & 8'hbf);
    stb_d = spb_d;
    stb_d[`RSR_SPB_NO_CMD] = 1'b0;
  end
  assign rqs = spb_q[`RSR_SPB_RQS];

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      sev_q <= 8'h00;
      mst_q <= 8'h00;
      ese_q <= `RSR_MASK_RST;
      sre_q <= `RSR_MASK_RST;
      mmask_q <= `RSR_MASK_RST;
      psc_q <= `RSR_PSC_RST;
      no_cmd_q <= 1'b1;
      opc_arm_q <= 1'b0;
      pon_q <= 1'b0;
      cal_q <= RSR_CAL_OK;
      spb_q <= 8'h00;
      stb_q <= 8'h00;
    end else begin
      sev_q <= sev_d;
      mst_q <= mst_d;
      ese_q <= ese_d;
      sre_q <= sre_d;
      mmask_q <= mmask_d;
      psc_q <= psc_d;
      no_cmd_q <= no_cmd_d;
      opc_arm_q <= opc_arm_d;
      pon_q <= pon_d;
      cal_q <= cal_d;
      spb_q <= spb_d;
      stb_q <= stb_d;
    end
  end

  // Power-on-clear setting reloaded from storage on the power-on edge is
  // left to the parser: it writes i_psc_wr from i_psc_nv after power-up.
  logic unused_psc_nv;
  assign unused_psc_nv = i_psc_nv | i_stb_query;

  // Serial poll byte is the only path that shows the queue flag
  assign o_spoll_byte = spb_q;
  assign o_stb_query_byte = stb_q;
  assign o_standard_event_status = sev_q;
  assign o_measurement_status = mst_q;
  assign o_ese_mask = ese_q;
  assign o_sre_mask = sre_q;
  assign o_meas_mask = mmask_q;
  assign o_psc = psc_q;
  assign o_cal_result = cal_q;
  assign o_srq = rqs;

  rsr_flash #(
    .FLASH_CYC(FLASH_CYC)
  ) u_act (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_trig(i_char_xfer),
    .o_lamp(o_activity_indicator)
  );

  rsr_flash #(
    .FLASH_CYC(FLASH_CYC)
  ) u_err (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_trig(i_cmd_err | i_exec_err | i_outq_overflow),
    .o_lamp(o_error_indicator)
  );

  logic rem_q;
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rem_q <= 1'b0;
    end else begin
      rem_q <= i_remote;
    end
  end
  assign o_remote_indicator = rem_q;
  assign o_panel_lockout = rem_q;
endmodule

// ---- dv/rsr_status_sva.sv ----
// Purpose: port checker for rsr_status
// Assumes: FLASH_CYC of at least 4
// Notes: bound from the bench top file
module rsr_status_sva #(
  parameter int unsigned FLASH_CYC = 4
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_cmd_err,
  input wire logic i_exec_err,
  input wire logic i_outq_overflow,
  input wire logic i_math_fault,
  input wire logic i_overload,
  input wire logic i_gpib_outq_nonempty,
  input wire logic i_cal_done,
  input wire logic [2:0] i_cal_code,
  input wire logic i_char_xfer,
  input wire logic i_remote,
  input wire logic [7:0] o_spoll_byte,
  input wire logic [7:0] o_stb_query_byte,
  input wire logic [7:0] o_standard_event_status,
  input wire logic [7:0] o_measurement_status,
  input wire logic [7:0] o_ese_mask,
  input wire logic [2:0] o_cal_result,
  input wire logic o_srq,
  input wire logic o_activity_indicator,
  input wire logic o_remote_indicator,
  input wire logic o_panel_lockout
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  logic esb_d;
  logic esb_q;
  always_comb esb_d = |(o_standard_event_status & o_ese_mask);
  always_ff @(posedge i_core_clk) begin
    esb_q <= esb_d;
  end
  a_cmd_err_sets: assert property (i_cmd_err |=> o_standard_event_status[5]) else $error("cmd err lost");
  a_exec_err_sets: assert property (i_exec_err |=> o_standard_event_status[4]) else $error("exec err lost");
  a_ovf_sets: assert property (i_outq_overflow |=> o_standard_event_status[2]) else $error("overflow lost");
  a_unused_zero: assert property (!(o_standard_event_status & 8'h0a) && !o_measurement_status[6])
    else $error("unused bit set");
  a_math_sets: assert property (i_math_fault |=> o_measurement_status[0]) else $error("math lost");
  a_ovld_holds: assert property (i_overload |=> o_measurement_status[2][*3]) else $error("overload lost");
  a_esb_sum: assert property (o_spoll_byte[5] == esb_q) else $error("esb wrong");
  a_mav_follow: assert property (!$past(i_rst) |-> o_spoll_byte[4] == $past(i_gpib_outq_nonempty))
    else $error("mav wrong");
  a_stb_nocmd: assert property (o_stb_query_byte[7] == 1'b0) else $error("query no-command set");
  a_srq_bit: assert property (o_srq == o_spoll_byte[6]) else $error("srq differs");
  a_cal_load: assert property (i_cal_done && i_cal_code <= 3'h4 |=> o_cal_result == $past(i_cal_code))
    else $error("cal code wrong");
  a_act_flash: assert property (i_char_xfer |=> o_activity_indicator[*4]) else $error("activity short");
  a_remote_lamp: assert property (!$past(i_rst) |->
    o_remote_indicator == $past(i_remote) && o_panel_lockout == $past(i_remote)) else $error("remote wrong");
endmodule

// ---- dv/rsr_host.sv ----
// Purpose: host computer issuing status commands
// Assumes: one command at a time
// Notes: data inverted once released so stale values never match
module rsr_host (
  // Clock
  input wire logic i_core_clk,
  // Command strobes and data
  output logic o_cls,
  output logic o_opc,
  output logic o_ese_wr,
  output logic o_sre_wr,
  output logic o_mask_wr,
  output logic o_psc_wr,
  output logic o_psc_val,
  output logic [7:0] o_data
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {o_psc_wr, o_mask_wr, o_sre_wr, o_ese_wr, o_opc, o_cls} = 6'h00;
    o_psc_val = 1'b0;
    o_data = 8'h00;
  end
  // Op 0 clear, 1 complete, 2..4 masks, 5 power-on clear
  task automatic send(input int op, input logic [7:0] v);
    @(posedge i_core_clk) #1;
    o_data = v;
    o_psc_val = v[0];
    {o_psc_wr, o_mask_wr, o_sre_wr, o_ese_wr, o_opc, o_cls} = 6'h01 << op;
    @(posedge i_core_clk) #1;
    {o_psc_wr, o_mask_wr, o_sre_wr, o_ese_wr, o_opc, o_cls} = 6'h00;
    o_data = ~v;
    o_psc_val = ~v[0];
  endtask
endmodule

// ---- dv/rsr_status_test.sv ----
// Purpose: self-checking bench for rsr_status
// Assumes: flash time cut to 4 cycles
// Notes: reset checks first, then event rows, then hand tests
module rsr_status_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_core_clk, i_rst, i_power_on, i_psc_nv, i_settings_invalid, i_psc_val, i_stb_query;
  logic i_cls, i_opc_cmd, i_psc_wr, i_ese_wr, i_sre_wr, i_measurement_mask_write;
  logic i_gpib_outq_nonempty, i_ready, i_meas_busy, i_remote, i_cal_done, i_key_press, i_char_xfer;
  logic i_cmd_enqueued, i_queue_drained, i_cmd_err, i_exec_err, i_outq_overflow, i_math_fault;
  logic i_adc_fault, i_overload, i_under_range, i_over_range, i_no_meas;
  logic [2:0] i_cal_code, o_cal_result;
  logic [7:0] i_mask_data, o_spoll_byte, o_stb_query_byte, o_standard_event_status, o_measurement_status;
  logic [7:0] o_ese_mask, o_sre_mask, o_meas_mask;
  logic o_psc, o_srq, o_activity_indicator, o_error_indicator, o_remote_indicator, o_panel_lockout;
  logic [13:0] ev;
  int miscompares, check_count;
  // Row: source index, expected event byte, expected measurement byte
  localparam logic [19:0] ROWS [10] = '{20'h12000, 20'h21000, 20'h30400, 20'h44000, 20'h50001,
    20'h60002, 20'h70004, 20'h80008, 20'h90010, 20'ha0020};
  assign {i_cal_done, i_queue_drained, i_cmd_enqueued, i_no_meas, i_over_range, i_under_range, i_overload,
    i_adc_fault, i_math_fault, i_key_press, i_outq_overflow, i_exec_err, i_cmd_err, i_char_xfer} = ev;
  rsr_status #(.FLASH_CYC(4)) dut (.*);
  rsr_host host (.i_core_clk, .o_cls(i_cls), .o_opc(i_opc_cmd), .o_ese_wr(i_ese_wr), .o_sre_wr(i_sre_wr),
    .o_mask_wr(i_measurement_mask_write), .o_psc_wr(i_psc_wr), .o_psc_val(i_psc_val), .o_data(i_mask_data));
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic pulse(input int k);
    @(posedge i_core_clk) #1;
    ev = 14'h1 << k;
    @(posedge i_core_clk) #1;
    ev = '0;
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    i_core_clk = 1'b0;
    forever #12.5 i_core_clk = ~i_core_clk;
  end
  // Whole run is under 120 cycles
  initial begin
    repeat (3000) @(posedge i_core_clk);
    miscompares++;
    complete_run();
  end
  initial begin
    {i_power_on, i_psc_nv, i_settings_invalid, i_stb_query, i_gpib_outq_nonempty, i_meas_busy, i_remote} = '0;
    i_cal_code = 3'h0;
    i_ready = 1'b1;
    ev = '0;
    i_rst = 1'b1;
    repeat (5) @(posedge i_core_clk);
    #1 i_rst = 1'b0;
    wait_clk(2);
    check("spoll", o_spoll_byte, 8'h81);
    check("sev", o_standard_event_status | o_measurement_status | o_ese_mask, 8'h00);
    check("psc cal", {4'h0, o_psc, o_cal_result}, 8'h08);
    $display("test reset end");
    host.send(2, 8'hff);
    host.send(4, 8'hff);
    check("ese", o_ese_mask, 8'hff);
    check("mmask", o_meas_mask, 8'hff);
    foreach (ROWS[r]) begin
      host.send(0, 8'h00);
      pulse(int'(ROWS[r][19:16]));
      wait_clk(1);
      check("sev", o_standard_event_status, ROWS[r][15:8]);
      check("mst", o_measurement_status, ROWS[r][7:0]);
      check("sum", o_spoll_byte & 8'h28, {2'h0, |ROWS[r][15:8], 1'b0, |ROWS[r][7:0], 3'h0});
    end
    $display("test rows end");
    pulse(11);
    wait_clk(1);
    check("nocmd", o_spoll_byte & 8'h80, 8'h00);
    pulse(12);
    wait_clk(1);
    check("nocmd", o_spoll_byte & 8'h80, 8'h80);
    check("query", o_stb_query_byte & 8'h80, 8'h00);
    i_gpib_outq_nonempty = 1'b1;
    i_ready = 1'b0;
    wait_clk(2);
    check("mav", o_spoll_byte & 8'h11, 8'h10);
    $display("test queue end");
    host.send(3, 8'h20);
    check("sre", o_sre_mask, 8'h20);
    pulse(1);
    wait_clk(2);
    check("srq", {o_spoll_byte[7:1], o_srq}, 8'hf9);
    $display("test srq end");
    host.send(0, 8'h00);
    i_meas_busy = 1'b1;
    host.send(1, 8'h00);
    wait_clk(3);
    check("opc", o_standard_event_status & 8'h01, 8'h00);
    i_meas_busy = 1'b0;
    wait_clk(3);
    check("opc", o_standard_event_status & 8'h01, 8'h01);
    $display("test opc end");
    for (int c = 0; c <= 4; c++) begin
      i_cal_code = 3'(c);
      pulse(13);
      check("cal", {5'h0, o_cal_result}, 8'(c));
    end
    $display("test cal end");
    pulse(0);
    check("act", {7'h0, o_activity_indicator}, 8'h01);
    wait_clk(6);
    check("act", {7'h0, o_activity_indicator}, 8'h00);
    pulse(2);
    check("err", {7'h0, o_error_indicator}, 8'h01);
    i_remote = 1'b1;
    wait_clk(1);
    check("rem", {6'h0, o_remote_indicator, o_panel_lockout}, 8'h03);
    i_remote = 1'b0;
    wait_clk(1);
    check("rem", {6'h0, o_remote_indicator, o_panel_lockout}, 8'h00);
    $display("test lamps end");
    host.send(5, 8'h00);
    check("psc", {7'h0, o_psc}, 8'h00);
    host.send(5, 8'h01);
    i_settings_invalid = 1'b1;
    i_power_on = 1'b1;
    wait_clk(3);
    check("pon", {o_standard_event_status[7], o_measurement_status[7], o_ese_mask[5:0]}, 8'hc0);
    $display("test power end");
    complete_run();
  end
endmodule
bind rsr_status rsr_status_sva #(.FLASH_CYC(FLASH_CYC)) u_sva (.*);
